// ### hdl/ipw_map.vh
// Register offsets, field positions, reset values and source layout of the interrupt and wake block
`ifndef IPW_MAP_VH
`define IPW_MAP_VH
// Register byte offsets
`define IPW_REG_CTRL 8'h00
`define IPW_REG_EN_LO 8'h04
`define IPW_REG_EN_HI 8'h08
`define IPW_REG_LEVEL 8'h0c
`define IPW_REG_STBY 8'h10
`define IPW_REG_STATUS 8'h14
`define IPW_REG_SRC_LO 8'h18
`define IPW_REG_SRC_HI 8'h1c
// Control fields
`define IPW_CTRL_GIE 0
`define IPW_CTRL_PIN0_LVL 1
`define IPW_CTRL_PIN1_LVL 2
`define IPW_CTRL_BTMR_LRC 3
// Reset values
`define IPW_CTRL_RST 4'h0
`define IPW_EN_RST 44'h000_0000_0000
`define IPW_LEVEL_RST 10'h000
// Service levels
`define IPW_LVL_NONE 2'h0
`define IPW_LVL_LOW 2'h1
`define IPW_LVL_HIGH 2'h2
`define IPW_LVL_TOP 2'h3
// Standby modes
`define IPW_MODE_RUN 2'h0
`define IPW_MODE_PAUSE 2'h1
`define IPW_MODE_STOP 2'h2
`define IPW_MODE_XTAL 2'h3
// Vector geometry
`define IPW_NUM_SRC 44
`define IPW_NUM_VEC 10
`define IPW_VEC_BASE 8'h03
`define IPW_VEC_STEP 8'h08
// First source index of vectors one to nine
`define IPW_V1_LO 1
`define IPW_V2_LO 2
`define IPW_V3_LO 8
`define IPW_V4_LO 11
`define IPW_V5_LO 16
`define IPW_V6_LO 24
`define IPW_V7_LO 26
`define IPW_V8_LO 31
`define IPW_V9_LO 38
// Sources that take part in stop release
`define IPW_SRC_PIN0 0
`define IPW_SRC_PIN1 1
`define IPW_SRC_PIN2 2
`define IPW_SRC_PIN4 4
`define IPW_SRC_USBA_BUS 5
`define IPW_SRC_USBB_BUS 6
`define IPW_SRC_IR_RX 7
`define IPW_SRC_PIN5 9
`define IPW_SRC_BTMR 10
`define IPW_SRC_PORT0 38
`endif

// ### hdl/ipw_ctrl.v
// Interrupt priority arbiter and standby wake controller with APB registers
//
// Summary of operation
// - Three nested levels; refuse equal or lower
// - Highest level wins, then lowest vector
// - Forty-four sources merged onto ten vectors
// - Pins zero/one at 03/0B, top or low
// - Vectors 13 to 4B: high or low only
// - Vector 13 gathers its six sources
// - Vector 1B gathers pin3, pin5, base timer
// - Vector 23 gathers its five sources
// - Vector 2B gathers its eight sources
// - Vector 33 gathers serial one, async receive
// - Vector 3B gathers its five sources
// - Vector 43 gathers its seven sources
// - Vector 4B gathers its six sources
// - Pause stops core; resets or interrupt release
// - Stop halts core, peripherals, all oscillators
// - Stop released by five cause groups
// - Pins zero/one release stop only in level mode
// - Crystal stop keeps timer, receiver, crystal state
// - Crystal stop adds timer and receiver release
// - Slow RC kept when timer uses it
`timescale 1ns/1ps
`default_nettype none
`include "ipw_map.vh"
module ipw_ctrl (
	// Clock and reset
	input wire clk,
	input wire rst_n,
	// APB slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output wire pready,
	output wire pslverr,
	// Request sources, one bit each, level high
	input wire [43:0] src_req,
	// Reset causes that also release standby
	input wire reset_pin_low,
	input wire wdt_reset,
	input wire low_voltage_reset,
	// Oscillator state sampled on crystal-stop entry
	input wire xtal_running,
	input wire lrc_running,
	// Core side
	output reg irq_req,
	output reg [7:0] irq_vec_addr,
	output reg [1:0] irq_level,
	input wire irq_ack,
	input wire irq_ret,
	// Run and oscillator permits
	output wire core_run,
	output wire periph_run,
	output wire btmr_ir_run,
	output wire pll_allow,
	output wire ceramic_allow,
	output wire rc_allow,
	output wire xtal_allow,
	output wire lrc_allow
);

	reg [3:0] ctrl_q;
	reg [43:0] en_q;
	reg [9:0] lvlsel_q;
	reg [1:0] mode_q;
	reg xtal_keep_q;
	reg lrc_keep_q;
	reg [1:0] cur_q;
	reg [1:0] stk0_q;
	reg [1:0] stk1_q;
	reg [1:0] stk2_q;
	reg [1:0] sp_q;
	reg [9:0] vreq;
	wire [19:0] vlvl;
	wire [9:0] vec_elig;
	reg found;
	reg [3:0] win_idx;
	reg [1:0] win_lvl;
	reg [31:0] rd_d;
	reg dec_ok;
	wire wr_en;
	wire rd_setup;
	wire sys_reset;
	wire [43:0] src_on;
	wire stop_wake;
	wire xtal_wake;
	wire pause_wake;
	wire ack_take;
	wire ret_take;
	wire stby_wr;
	wire wr_ctrl;
	wire wr_en_lo;
	wire wr_en_hi;
	wire wr_level;
	wire wake_level01;
	wire wake_pins;
	wire wake_port0;
	wire wake_usb;
	wire wake_timer_ir;
	integer i;
	integer v;

	// Source index to vector index
	// Sources of one vector sit on consecutive indices, so a threshold walk is enough
	function [3:0] src_vec;
		input integer s;
		begin
			if (s >= `IPW_V9_LO)
				src_vec = 4'd9;
			else if (s >= `IPW_V8_LO)
				src_vec = 4'd8;
			else if (s >= `IPW_V7_LO)
				src_vec = 4'd7;
			else if (s >= `IPW_V6_LO)
				src_vec = 4'd6;
			else if (s >= `IPW_V5_LO)
				src_vec = 4'd5;
			else if (s >= `IPW_V4_LO)
				src_vec = 4'd4;
			else if (s >= `IPW_V3_LO)
				src_vec = 4'd3;
			else if (s >= `IPW_V2_LO)
				src_vec = 4'd2;
			else if (s >= `IPW_V1_LO)
				src_vec = 4'd1;
			else
				src_vec = 4'd0;
		end
	endfunction

	assign src_on = src_req & en_q;
	assign sys_reset = reset_pin_low | wdt_reset | low_voltage_reset;

	// Group enabled sources onto their vectors
	// Sources are levels; the flags themselves live in the peripherals
	always @* begin
		vreq = 10'h000;
		for (i = 0; i < `IPW_NUM_SRC; i = i + 1) begin
			if (src_on[i])
				vreq[src_vec(i)] = 1'b1;
		end
	end

	// Level per vector; top level only reachable on the two pin vectors
	genvar g;
	generate
		for (g = 0; g < `IPW_NUM_VEC; g = g + 1) begin : g_lvl
			if (g < 2) begin : g_pin
				assign vlvl[2*g+1:2*g] = lvlsel_q[g] ? `IPW_LVL_TOP : `IPW_LVL_LOW;
			end else begin : g_per
				assign vlvl[2*g+1:2*g] = lvlsel_q[g] ? `IPW_LVL_HIGH : `IPW_LVL_LOW;
			end
			// Only a level above the one in service may interrupt
			assign vec_elig[g] = ctrl_q[`IPW_CTRL_GIE] & vreq[g] & (vlvl[2*g+1:2*g] > cur_q);
		end
	endgenerate

	// Downward scan with >= lets the lower vector win a tie
	always @* begin
		found = 1'b0;
		win_idx = 4'h0;
		win_lvl = `IPW_LVL_NONE;
		for (v = `IPW_NUM_VEC - 1; v >= 0; v = v - 1) begin
			if (vec_elig[v] && vlvl[2*v+1 -: 2] >= win_lvl) begin
				found = 1'b1;
				win_idx = v[3:0];
				win_lvl = vlvl[2*v+1 -: 2];
			end
		end
	end

	// Grant outputs; cleared on acknowledge so a stale grant is never taken twice
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_req <= 1'b0;
			irq_vec_addr <= 8'h00;
			irq_level <= `IPW_LVL_NONE;
		end else begin
			irq_req <= found & ~irq_ack & ~irq_ret & ~sys_reset;
			// Eight address steps per vector index
			irq_vec_addr <= `IPW_VEC_BASE + {1'b0, win_idx, 3'b000};
			irq_level <= win_lvl;
		end
	end

	// A lone ack or a return on an empty stack is ignored
	assign ack_take = irq_ack & irq_req;
	assign ret_take = irq_ret & (sp_q != 2'd0);

	// Service level stack, three deep covers low, high and top nesting
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cur_q <= `IPW_LVL_NONE;
			stk0_q <= `IPW_LVL_NONE;
			stk1_q <= `IPW_LVL_NONE;
			stk2_q <= `IPW_LVL_NONE;
			sp_q <= 2'd0;
		end else if (sys_reset) begin
			cur_q <= `IPW_LVL_NONE;
			sp_q <= 2'd0;
		end else if (ack_take) begin
			cur_q <= irq_level;
			stk2_q <= stk1_q;
			stk1_q <= stk0_q;
			stk0_q <= cur_q;
			// Saturates; three levels never need a fourth entry
			if (sp_q != 2'd3)
				sp_q <= sp_q + 2'd1;
		end else if (ret_take) begin
			cur_q <= stk0_q;
			stk0_q <= stk1_q;
			stk1_q <= stk2_q;
			stk2_q <= `IPW_LVL_NONE;
			sp_q <= sp_q - 2'd1;
		end
	end

	// Release causes; edge-mode pins zero and one are left out of both stop types
	assign wake_level01 = (src_on[`IPW_SRC_PIN0] & ctrl_q[`IPW_CTRL_PIN0_LVL]) |
		(src_on[`IPW_SRC_PIN1] & ctrl_q[`IPW_CTRL_PIN1_LVL]);
	assign wake_pins = src_on[`IPW_SRC_PIN2] | src_on[`IPW_SRC_PIN4] | src_on[`IPW_SRC_PIN5];
	assign wake_port0 = src_on[`IPW_SRC_PORT0];
	assign wake_usb = src_on[`IPW_SRC_USBA_BUS] | src_on[`IPW_SRC_USBB_BUS];
	assign wake_timer_ir = src_on[`IPW_SRC_BTMR] | src_on[`IPW_SRC_IR_RX];
	assign stop_wake = sys_reset | wake_level01 | wake_pins | wake_port0 | wake_usb;
	assign xtal_wake = stop_wake | wake_timer_ir;
	// Pause ignores the global enable: any pending vector ends it
	assign pause_wake = sys_reset | (|vreq);

	// Standby mode sequencer
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mode_q <= `IPW_MODE_RUN;
			xtal_keep_q <= 1'b0;
			lrc_keep_q <= 1'b0;
		end else begin
			// Oscillator states are sampled at entry and held until release
			case (mode_q)
				`IPW_MODE_RUN: begin
					if (stby_wr) begin
						mode_q <= pwdata[1:0];
						xtal_keep_q <= xtal_running;
						lrc_keep_q <= lrc_running;
					end
				end
				`IPW_MODE_PAUSE: begin
					if (pause_wake)
						mode_q <= `IPW_MODE_RUN;
				end
				`IPW_MODE_STOP: begin
					if (stop_wake)
						mode_q <= `IPW_MODE_RUN;
				end
				`IPW_MODE_XTAL: begin
					if (xtal_wake)
						mode_q <= `IPW_MODE_RUN;
				end
				default: begin
					mode_q <= `IPW_MODE_RUN;
				end
			endcase
		end
	end

	// Permits; pause leaves oscillators as they are
	assign core_run = (mode_q == `IPW_MODE_RUN);
	assign periph_run = (mode_q == `IPW_MODE_RUN) || (mode_q == `IPW_MODE_PAUSE);
	assign btmr_ir_run = (mode_q != `IPW_MODE_STOP);
	assign pll_allow = periph_run;
	assign ceramic_allow = periph_run;
	assign rc_allow = periph_run;
	assign xtal_allow = periph_run | ((mode_q == `IPW_MODE_XTAL) & xtal_keep_q);
	assign lrc_allow = periph_run |
		((mode_q == `IPW_MODE_XTAL) & ctrl_q[`IPW_CTRL_BTMR_LRC] & lrc_keep_q);

	// APB: zero wait states, read data captured in the setup cycle
	assign pready = 1'b1;
	assign wr_en = psel & penable & pwrite;
	assign rd_setup = psel & ~penable & ~pwrite;
	// Standby entry refused while a reset cause is high, so the core never sleeps through it
	assign stby_wr = wr_en & (paddr == `IPW_REG_STBY) & ~sys_reset;
	assign wr_ctrl = wr_en & (paddr == `IPW_REG_CTRL);
	assign wr_en_lo = wr_en & (paddr == `IPW_REG_EN_LO);
	assign wr_en_hi = wr_en & (paddr == `IPW_REG_EN_HI);
	assign wr_level = wr_en & (paddr == `IPW_REG_LEVEL);

	always @* begin
		dec_ok = 1'b1;
		rd_d = 32'h0000_0000;
		case (paddr)
			`IPW_REG_CTRL: rd_d[3:0] = ctrl_q;
			`IPW_REG_EN_LO: rd_d = en_q[31:0];
			`IPW_REG_EN_HI: rd_d[11:0] = en_q[43:32];
			`IPW_REG_LEVEL: rd_d[9:0] = lvlsel_q;
			`IPW_REG_STBY: rd_d[1:0] = mode_q;
			`IPW_REG_STATUS: begin
				rd_d[1:0] = cur_q;
				rd_d[3:2] = sp_q;
				rd_d[4] = found;
				rd_d[11:8] = win_idx;
				rd_d[25:16] = vreq;
			end
			`IPW_REG_SRC_LO: rd_d = src_req[31:0];
			`IPW_REG_SRC_HI: rd_d[11:0] = src_req[43:32];
			default: dec_ok = 1'b0;
		endcase
	end

	assign pslverr = psel & penable & ~dec_ok;

	// Captured in setup, so the word stands through the access cycle
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			prdata <= 32'h0000_0000;
		else if (rd_setup)
			prdata <= rd_d;
	end

	// Register writes
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_q <= `IPW_CTRL_RST;
			en_q <= `IPW_EN_RST;
			lvlsel_q <= `IPW_LEVEL_RST;
		end else begin
			// Status and source words are read-only; writes there fall away
			if (wr_ctrl)
				ctrl_q <= pwdata[3:0];
			if (wr_en_lo)
				en_q[31:0] <= pwdata;
			if (wr_en_hi)
				en_q[43:32] <= pwdata[11:0];
			if (wr_level)
				lvlsel_q <= pwdata[9:0];
		end
	end

endmodule
`default_nettype wire

// ### testbench/ipw_ctrl_properties.sv
// Checker on the arbiter, bus and standby outputs
`timescale 1ns/1ps
`default_nettype none
module ipw_ctrl_properties (
	// Clock and reset
	input wire clk,
	input wire rst_n,
	// Bus
	input wire psel,
	input wire penable,
	input wire [7:0] paddr,
	input wire pready,
	input wire pslverr,
	// Causes and core side
	input wire reset_pin_low,
	input wire wdt_reset,
	input wire low_voltage_reset,
	input wire irq_req,
	input wire [7:0] irq_vec_addr,
	input wire [1:0] irq_level,
	input wire irq_ack,
	input wire irq_ret,
	// Run permits
	input wire core_run,
	input wire periph_run,
	input wire btmr_ir_run,
	input wire pll_allow,
	input wire ceramic_allow,
	input wire rc_allow,
	input wire xtal_allow,
	input wire lrc_allow
);
	wire cause = reset_pin_low || wdt_reset || low_voltage_reset;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// Returns and resets move the level, so they are kept out
	sequence s_take;
		irq_req && irq_ack && !irq_ret && !cause;
	endsequence
	sequence s_quiet;
		!irq_ret && !cause;
	endsequence
	take_drop_a: assert property (s_take |=> !irq_req)
		else $error("offer stayed after take");
	nest_only_a: assert property (s_take ##1 s_quiet |=> !irq_req || irq_level > $past(irq_level, 2))
		else $error("equal or lower level offered");
	wake_cause_a: assert property (cause |=> core_run)
		else $error("reset cause left core halted");
	stop_halt_a: assert property (!btmr_ir_run |-> !periph_run && !core_run && !xtal_allow && !lrc_allow)
		else $error("stop left something running");
	osc_follow_a: assert property (pll_allow == periph_run && ceramic_allow == periph_run && rc_allow == periph_run)
		else $error("fast oscillators wrong");
	pause_keep_a: assert property (periph_run |-> xtal_allow && lrc_allow && btmr_ir_run)
		else $error("pause stopped an oscillator");
	top_pins_a: assert property (irq_req && irq_level == 2'h3 |-> irq_vec_addr <= 8'h0b)
		else $error("top level off the pin vectors");
	high_rest_a: assert property (irq_req && irq_level == 2'h2 |-> irq_vec_addr >= 8'h13)
		else $error("high level on a pin vector");
	vec_grid_a: assert property (irq_req |-> irq_vec_addr[2:0] == 3'h3 && irq_vec_addr <= 8'h4b && irq_level != 2'h0)
		else $error("vector off the grid");
	bus_err_a: assert property (psel && penable && paddr > 8'h1c |-> pslverr && pready)
		else $error("unmapped access not refused");
endmodule
bind ipw_ctrl ipw_ctrl_properties chk_u (.clk, .rst_n, .psel, .penable, .paddr, .pready, .pslverr, .reset_pin_low,
	.wdt_reset, .low_voltage_reset, .irq_req, .irq_vec_addr, .irq_level, .irq_ack, .irq_ret, .core_run, .periph_run,
	.btmr_ir_run, .pll_allow, .ceramic_allow, .rc_allow, .xtal_allow, .lrc_allow);
`default_nettype wire

// ### testbench/ipw_core_model.sv
// Core stand-in that takes offered interrupts, at random pace
`timescale 1ns/1ps
`default_nettype none
module ipw_core_model (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Offer and answer
	input wire logic irq_req,
	input wire logic auto_ack,
	output logic irq_ack
);
	// One pulse per offer, so a take is never counted twice
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			irq_ack <= 1'b0;
		else
			irq_ack <= auto_ack && irq_req && !irq_ack;
	end
endmodule
`default_nettype wire

// ### testbench/ipw_ctrl_bench.sv
// Self-checking bench for the interrupt and wake controller
`timescale 1ns/1ps
`default_nettype none
module ipw_ctrl_bench;
	logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, irq_ret = 0, en_ack = 0, auto_ack = 0, err;
	logic reset_pin_low = 0, wdt_reset = 0, low_voltage_reset = 0, xtal_running = 0, lrc_running = 0;
	logic [7:0] paddr = 0;
	logic [31:0] pwdata = 0, rd;
	logic [43:0] src_req = 0;
	logic [9:0] lvl;
	logic [9:0] q[$];
	wire [31:0] prdata;
	wire [7:0] irq_vec_addr;
	wire [1:0] irq_level;
	wire pready, pslverr, irq_req, irq_ack, core_run, periph_run, btmr_ir_run;
	wire pll_allow, ceramic_allow, rc_allow, xtal_allow, lrc_allow;
	int n_fail = 0, samples_checked = 0, seed = 19255, acks = 0, a, b, w, p;
	int lo[10] = '{0, 1, 2, 8, 11, 16, 24, 26, 31, 38};
	int ct[9] = '{0, 0, 2, 8, 0, 8, 4, 8, 0};
	int md[9] = '{2, 2, 2, 3, 1, 2, 2, 3, 3};
	int sr[9] = '{10, 0, 0, 10, 20, 7, 1, 7, 1};
	int wk[9] = '{0, 0, 1, 1, 1, 0, 1, 1, 0};
	always #12.5 clk = ~clk;
	always @(posedge clk) auto_ack <= en_ack && $random(seed) % 2;
	ipw_ctrl dut_u (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .src_req,
		.reset_pin_low, .wdt_reset, .low_voltage_reset, .xtal_running, .lrc_running, .irq_req, .irq_vec_addr,
		.irq_level, .irq_ack, .irq_ret, .core_run, .periph_run, .btmr_ir_run, .pll_allow, .ceramic_allow,
		.rc_allow, .xtal_allow, .lrc_allow);
	ipw_core_model core_u (.clk, .rst_n, .irq_req, .auto_ack, .irq_ack);
	function int vec(int s);
		vec = 0;
		for (int i = 0; i < 10; i++)
			if (s >= lo[i]) vec = i;
	endfunction
	function int lv(int v);
		lv = lvl[v] ? (v < 2 ? 3 : 2) : 1;
	endfunction
	function logic [9:0] ex(int v);
		ex = {8'(3 + 8 * v), 2'(lv(v))};
	endfunction
	task chk(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e) begin
			n_fail++;
			$display("MISMATCH %0t got %h exp %h", $time, g, e);
		end
	endtask
	task apb(input logic wr, input logic [7:0] ad, input logic [31:0] d);
		@(posedge clk);
		psel <= 1;
		pwrite <= wr;
		paddr <= ad;
		pwdata <= d;
		@(posedge clk);
		penable <= 1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task wack;
		int n;
		n = acks + 1;
		for (int k = 0; k < 60 && acks < n; k++) @(posedge clk);
		chk(acks, n);
	endtask
	task ret;
		@(posedge clk) irq_ret <= 1;
		@(posedge clk) irq_ret <= 0;
	endtask
	task end_of_test;
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	always @(posedge clk) begin
		if (irq_req && irq_ack) begin
			acks++;
			chk({irq_vec_addr, irq_level}, q.pop_front());
		end
	end
	initial begin
		#200us;
		n_fail++;
		end_of_test;
	end
	initial begin
		repeat (5) @(posedge clk);
		rst_n <= 1;
		apb(0, 8'h20, 0);
		chk(err, 1);
		chk(rd, 0);
		lvl = 10'($random(seed));
		lvl[0] = 1;
		lvl[2] = 0;
		apb(1, 8'h0c, 32'(lvl));
		apb(1, 8'h04, '1);
		apb(1, 8'h08, 32'hfff);
		apb(1, 8'h00, 1);
		apb(0, 8'h0c, 0);
		chk(rd, 32'(lvl));
		en_ack <= 1;
		// Every source alone, to its own vector
		for (int s = 0; s < 44; s++) begin
			q.push_back(ex(vec(s)));
			src_req[s] <= 1;
			wack();
			src_req[s] <= 0;
			ret();
		end
		// Top pin nests over a low handler
		q.push_back(ex(2));
		q.push_back(ex(0));
		src_req[2] <= 1;
		wack();
		src_req[0] <= 1;
		wack();
		src_req <= 0;
		ret();
		ret();
		repeat (20) begin
			a = {$random(seed)} % 44;
			b = (a + 1 + {$random(seed)} % 43) % 44;
			w = (lv(vec(a)) > lv(vec(b)) || (lv(vec(a)) == lv(vec(b)) && a < b)) ? a : b;
			q.push_back(ex(vec(w)));
			q.push_back(ex(vec(a + b - w)));
			src_req[a] <= 1;
			src_req[b] <= 1;
			wack();
			src_req[w] <= 0;
			repeat (3) @(posedge clk);
			chk(irq_req, 0);
			ret();
			wack();
			src_req <= 0;
			ret();
		end
		en_ack <= 0;
		for (int i = 0; i < 9; i++) begin
			{xtal_running, lrc_running} <= 2'($random(seed));
			apb(1, 8'h00, ct[i]);
			apb(1, 8'h10, md[i]);
			@(negedge clk);
			p = md[i] == 1;
			chk(core_run, 0);
			chk(periph_run, p);
			chk(btmr_ir_run, md[i] != 2);
			chk({pll_allow, ceramic_allow, rc_allow}, {3{p[0]}});
			chk(xtal_allow, p || md[i] == 3 && xtal_running);
			chk(lrc_allow, p || md[i] == 3 && ct[i][3] && lrc_running);
			@(posedge clk) src_req[sr[i]] <= 1;
			repeat (3) @(posedge clk);
			@(negedge clk) chk(core_run, wk[i]);
			@(posedge clk) src_req <= 0;
			wdt_reset <= 1;
			@(posedge clk) wdt_reset <= 0;
			@(negedge clk) chk(core_run, 1);
		end
		end_of_test;
	end
endmodule
`default_nettype wire
